// ---- usage_log_cfg.svh ----
`ifndef USAGE_LOG_CFG_SVH
`define USAGE_LOG_CFG_SVH
// How it works
// [RULE1] Sample every 4 s to 60 min.
// [RULE2] Enable takes effect at next power-up.
// [RULE3] Log entries go to non-volatile store.
// [RULE4] Sample five quantities each interval.
// [RULE5] Periodic circular entry of five quantities.
// [RULE6] Same interval bumps selected memory counter.
// [RULE7] Counters yield total powered-on time.
// [RULE8] Room for 750 entries, four counters.
// [RULE9] Checksum covers entries and counters.
// [RULE10] Extra entry on memory, volume, battery change.
// [RULE11] Optional entry on large ambient change.
// [RULE12] Fitting software reads out the log.
// [RULE13] Full buffer wraps, overwrites oldest, rechecksums; code adds the new entry but keeps the overwritten one in the sum.

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define LOG_CLK_HZ        100_000_000
`define LOG_TICK_MS       1
`define LOG_TICK_CYCLES   (`LOG_CLK_HZ / 1000 * `LOG_TICK_MS)
`define LOG_MIN_PERIOD_S  4
`define LOG_MAX_PERIOD_S  3600
`define LOG_MIN_PERIOD_MS (`LOG_MIN_PERIOD_S * 1000)
`define LOG_MAX_PERIOD_MS (`LOG_MAX_PERIOD_S * 1000)

// -----------------------------------------------------------------------------
// Store layout, in words
// -----------------------------------------------------------------------------
`define LOG_ENTRIES       750
`define LOG_COUNTERS      4
`define LOG_CNT_BASE      16'h0000
`define LOG_ENTRY_BASE    16'h0010
`define LOG_SUM_ADDR      16'h0008
`define LOG_PTR_ADDR      16'h0009
`define LOG_FLAG_ADDR     16'h000A
`define LOG_SUM_RESET     32'h0000_0000
`endif

// ---- usage_log_pkg.sv ----
package usage_log_pkg;
  typedef struct packed {
    logic [7:0] battery;
    logic [7:0] volume;
    logic [1:0] memory;
    logic [2:0] environment;
    logic [7:0] ambient;
  } sample_s;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } nvm_req_s;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_RDCNT = 7'b000_0010,
    ST_WRENT = 7'b000_0100,
    ST_WRCNT = 7'b000_1000,
    ST_WRPTR = 7'b001_0000,
    ST_WRSUM = 7'b010_0000,
    ST_WAIT  = 7'b100_0000
  } log_state_e;
endpackage : usage_log_pkg

// ---- log_tick_gen.sv ----
`timescale 1ns/1ns
`include "usage_log_cfg.svh"
module log_tick_gen
  import usage_log_pkg::*;
#(
  parameter int TICK_CYCLES = `LOG_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        run,
  input  wire logic [21:0] periodMs,
  // Events
  output logic             sampleTick
);
  logic [31:0] divCnt_q;
  logic [31:0] divCnt_d;
  logic [21:0] msCnt_q;
  logic [21:0] msCnt_d;
  logic        msTick;
  logic [21:0] period;

  always_comb begin
    // [RULE1] clamp the interval
    if (periodMs < 22'(`LOG_MIN_PERIOD_MS)) begin
      period = 22'(`LOG_MIN_PERIOD_MS);
    end else if (periodMs > 22'(`LOG_MAX_PERIOD_MS)) begin
      period = 22'(`LOG_MAX_PERIOD_MS);
    end else begin
      period = periodMs;
    end
    msTick   = run && (divCnt_q == 32'(TICK_CYCLES - 1));
    divCnt_d = (!run || msTick) ? 32'h0000_0000 : divCnt_q + 32'h0000_0001;
    sampleTick = msTick && (msCnt_q >= period - 22'h00_0001);
    if (!run || sampleTick) begin
      msCnt_d = 22'h00_0000;
    end else if (msTick) begin
      msCnt_d = msCnt_q + 22'h00_0001;
    end else begin
      msCnt_d = msCnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_q <= 32'h0000_0000;
      msCnt_q  <= 22'h00_0000;
    end else begin
      divCnt_q <= divCnt_d;
      msCnt_q  <= msCnt_d;
    end
  end
endmodule : log_tick_gen

// ---- input_sync.sv ----
`timescale 1ns/1ns
module input_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] synced
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;

  // Bits settle only when the second and third stages agree.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : synced[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      synced <= '0;
    end else begin
      s1_q   <= async;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      synced <= out_d;
    end
  end
endmodule : input_sync

// ---- usage_datalogger.sv ----
`timescale 1ns/1ns
`include "usage_log_cfg.svh"
module usage_datalogger
  import usage_log_pkg::*;
#(
  parameter int TICK_CYCLES = `LOG_TICK_CYCLES,
  parameter int ENTRIES     = `LOG_ENTRIES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration
  input  wire logic        logEnable,
  input  wire logic        powerUp,
  input  wire logic [21:0] periodMs,
  input  wire logic        levelTrigEn,
  input  wire logic [7:0]  levelThreshold,
  // Instrument state, from pins
  input  wire sample_s     sampleIn,
  // Non-volatile store
  output nvm_req_s         nvmReq,
  input  wire logic        nvmAck,
  input  wire logic [31:0] nvmRdata,
  // Status
  output logic             logging,
  output logic [31:0]      checksum,
  output logic [15:0]      writePtr,
  output logic             wrapped
);
  // ---------------------------------------------------------------------------
  // Inputs and interval
  // ---------------------------------------------------------------------------
  sample_s sample;
  logic    sampleTick;

  // [RULE4] sample all quantities
  input_sync #(.W($bits(sample_s))) u_sync (
    .clk    (clk),
    .rst    (rst),
    .async  (sampleIn),
    .synced (sample)
  );

  log_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk        (clk),
    .rst        (rst),
    .run        (logging),
    .periodMs   (periodMs),
    .sampleTick (sampleTick)
  );

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  log_state_e  state_q,   state_d;
  logic        armed_q,   armed_d;
  logic        run_q,     run_d;
  sample_s     last_q,    last_d;
  sample_s     ent_q,     ent_d;
  logic        periodic_q, periodic_d;
  logic        pendP_q,   pendP_d;
  logic        pendC_q,   pendC_d;
  logic [31:0] cnt_q,     cnt_d;
  logic [31:0] sum_q,     sum_d;
  logic [15:0] ptr_q,     ptr_d;
  logic        wrap_q,    wrap_d;
  logic        powerUpQ;
  logic        changed;
  logic [7:0]  ambDiff;
  nvm_req_s    req;

  // An entry word is the zero-extended sample. A plain sum is cheap to keep current,
  // but it cannot tell which slot a word sits in.
  function automatic logic [31:0] entryWord(input sample_s s);
    entryWord = {3'b000, s};
  endfunction : entryWord

  always_comb begin
    ambDiff = (sample.ambient > last_q.ambient) ? sample.ambient - last_q.ambient
                                                : last_q.ambient - sample.ambient;
    // [RULE10] tracked state change
    changed = (sample.memory != last_q.memory) || (sample.volume != last_q.volume)
           || (sample.battery != last_q.battery);
    // [RULE11] optional ambient trigger
    if (levelTrigEn && (ambDiff > levelThreshold)) begin
      changed = 1'b1;
    end
  end

  always_comb begin
    state_d    = state_q;
    armed_d    = armed_q;
    run_d      = run_q;
    last_d     = last_q;
    ent_d      = ent_q;
    periodic_d = periodic_q;
    pendP_d    = pendP_q || (run_q && sampleTick);
    pendC_d    = pendC_q || (run_q && changed && state_q == ST_IDLE);
    cnt_d      = cnt_q;
    sum_d      = sum_q;
    ptr_d      = ptr_q;
    wrap_d     = wrap_q;
    req        = '0;
    // [RULE2] enable waits for power-up
    if (!logEnable) begin
      armed_d = 1'b0;
      run_d   = 1'b0;
    end else if (!armed_q) begin
      armed_d = 1'b1;
    end else if (powerUp && !powerUpQ) begin
      run_d = 1'b1;
    end
    // Follow the inputs while stopped, so that a start does not log a false change.
    if (!run_q) begin
      last_d = sample;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (run_q && (pendP_q || pendC_q)) begin
          ent_d      = sample;
          last_d     = sample;
          periodic_d = pendP_q;
          // A tick that lands while a change entry is taken must stay pending.
          pendP_d    = sampleTick;
          pendC_d    = 1'b0;
          state_d    = pendP_q ? ST_RDCNT : ST_WRENT;
        end
      end
      ST_RDCNT: begin
        req.req  = 1'b1;
        req.addr = `LOG_CNT_BASE + {14'h0000, ent_q.memory};
        if (nvmAck) begin
          cnt_d   = nvmRdata;
          state_d = ST_WRENT;
        end
      end
      ST_WRENT: begin
        // [RULE5] append circular entry
        req.req   = 1'b1;
        req.wr    = 1'b1;
        req.addr  = `LOG_ENTRY_BASE + ptr_q;
        req.wdata = entryWord(ent_q);
        if (nvmAck) begin
          // [RULE9] checksum on update
          sum_d = sum_q + entryWord(ent_q);
          // [RULE13] wrap to slot zero
          if (ptr_q == 16'(ENTRIES - 1)) begin
            ptr_d  = 16'h0000;
            wrap_d = 1'b1;
          end else begin
            ptr_d = ptr_q + 16'h0001;
          end
          state_d = periodic_q ? ST_WRCNT : ST_WRPTR;
        end
      end
      ST_WRCNT: begin
        // [RULE6] bump memory counter
        req.req   = 1'b1;
        req.wr    = 1'b1;
        req.addr  = `LOG_CNT_BASE + {14'h0000, ent_q.memory};
        req.wdata = cnt_q + 32'h0000_0001;
        if (nvmAck) begin
          // [RULE7] counters track on-time
          sum_d   = sum_q + 32'h0000_0001;
          state_d = ST_WRPTR;
        end
      end
      ST_WRPTR: begin
        req.req   = 1'b1;
        req.wr    = 1'b1;
        req.addr  = `LOG_PTR_ADDR;
        req.wdata = {15'h0000, wrap_q, ptr_q};
        if (nvmAck) begin
          state_d = ST_WRSUM;
        end
      end
      ST_WRSUM: begin
        // [RULE3] persist checksum
        req.req   = 1'b1;
        req.wr    = 1'b1;
        req.addr  = `LOG_SUM_ADDR;
        req.wdata = sum_q;
        if (nvmAck) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      armed_q    <= 1'b0;
      run_q      <= 1'b0;
      powerUpQ   <= 1'b0;
      last_q     <= '0;
      ent_q      <= '0;
      periodic_q <= 1'b0;
      pendP_q    <= 1'b0;
      pendC_q    <= 1'b0;
      cnt_q      <= 32'h0000_0000;
      sum_q      <= `LOG_SUM_RESET;
      ptr_q      <= 16'h0000;
      wrap_q     <= 1'b0;
      nvmReq     <= '0;
    end else begin
      state_q    <= state_d;
      armed_q    <= armed_d;
      run_q      <= run_d;
      powerUpQ   <= powerUp;
      last_q     <= last_d;
      ent_q      <= ent_d;
      periodic_q <= periodic_d;
      pendP_q    <= pendP_d;
      pendC_q    <= pendC_d;
      cnt_q      <= cnt_d;
      sum_q      <= sum_d;
      ptr_q      <= ptr_d;
      wrap_q     <= wrap_d;
      nvmReq     <= req;
    end
  end

  // [RULE8] 750 slots, four counters
  assign logging  = run_q;
  assign checksum = sum_q;
  assign writePtr = ptr_q;
  assign wrapped  = wrap_q;
endmodule : usage_datalogger

// ---- usage_datalogger_checker.sv ----
`timescale 1ns/1ns
`include "usage_log_cfg.svh"
module usage_datalogger_checker
  import usage_log_pkg::*;
#(
  parameter int ENTRIES = `LOG_ENTRIES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Configuration
  input wire logic        powerUp,
  // Store side
  input wire nvm_req_s    nvmReq,
  input wire logic        nvmAck,
  input wire logic [31:0] nvmRdata,
  // Status
  input wire logic        logging,
  input wire logic [31:0] checksum,
  input wire logic [15:0] writePtr,
  input wire logic        wrapped
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [31:0] rdQ;
  logic [15:0] raQ;
  wire         isWr = nvmReq.req && nvmReq.wr;

  // The counter write must carry the value read back, plus one.
  always_ff @(posedge clk) begin
    if (nvmReq.req && !nvmReq.wr && nvmAck) begin
      rdQ <= nvmRdata;
      raQ <= nvmReq.addr;
    end
  end

  sequence s_cnt_rd;
    nvmReq.req && !nvmReq.wr && nvmAck;
  endsequence
  sequence s_ent_wr;
    isWr && nvmReq.addr >= `LOG_ENTRY_BASE;
  endsequence

  // The request stays on the bus for one cycle after its ack, while the pointer has
  // already moved on; that stale copy is left out of the hold and slot checks.
  a_idle_quiet: assert property (
    !logging && $past(!logging) |-> !nvmReq.req) else $error("store access while not logging");
  a_start_pwr: assert property (
    $rose(logging) |-> $past(powerUp, 1) || $past(powerUp, 2) || $past(powerUp, 3))
    else $error("logging started without power-up");
  a_ptr_range: assert property (
    writePtr < ENTRIES) else $error("write pointer out of range");
  a_ptr_step: assert property (
    $changed(writePtr) |-> writePtr == 16'($past(writePtr) + 1)
      || (writePtr == 0 && $past(writePtr) == ENTRIES - 1)) else $error("pointer skipped");
  a_wrap_flag: assert property (
    $changed(writePtr) && writePtr == 0 |-> ##[0:2] wrapped) else $error("wrap not flagged");
  a_req_hold: assert property (
    nvmReq.req && !nvmAck && !$past(nvmAck) |=> $stable(nvmReq))
    else $error("request changed before ack");
  a_cnt_incr: assert property (
    isWr && nvmReq.addr < `LOG_CNT_BASE + 16'(`LOG_COUNTERS)
      |-> nvmReq.wdata == rdQ + 1 && nvmReq.addr == raQ)
    else $error("counter not incremented");
  a_rd_then_ent: assert property (
    s_cnt_rd |-> ##[1:4] s_ent_wr) else $error("no entry after counter read");
  a_entry_slot: assert property (
    isWr && nvmReq.addr >= `LOG_ENTRY_BASE && !$past(nvmAck)
      |-> nvmReq.addr == `LOG_ENTRY_BASE + writePtr)
    else $error("entry slot wrong");
  a_ptr_word: assert property (
    isWr && nvmReq.addr == `LOG_PTR_ADDR |-> nvmReq.wdata == {15'h0000, wrapped, writePtr})
    else $error("pointer word wrong");
  a_sum_word: assert property (
    isWr && nvmReq.addr == `LOG_SUM_ADDR |-> nvmReq.wdata == checksum)
    else $error("sum word wrong");
endmodule : usage_datalogger_checker

bind usage_datalogger usage_datalogger_checker #(.ENTRIES(ENTRIES)) i_chk (
  .clk(clk), .rst(rst), .powerUp(powerUp), .nvmReq(nvmReq), .nvmAck(nvmAck),
  .nvmRdata(nvmRdata), .logging(logging), .checksum(checksum), .writePtr(writePtr),
  .wrapped(wrapped)
);

// ---- nvm_model.sv ----
`timescale 1ns/1ns
module nvm_model
  import usage_log_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Access
  input  wire nvm_req_s   nvmReq,
  output logic            nvmAck,
  output logic [31:0]     nvmRdata,
  // Answer delay in cycles
  input  wire logic [3:0] lat
);
  logic [31:0] mem [0:31];
  logic [3:0]  waitQ = 4'h0;
  logic        gapQ = 1'b0;

  initial begin
    nvmAck = 1'b0;
    for (int i = 0; i < 32; i++) mem[i] = 32'h0000_0000;
  end

  // The cycle after an ack still shows the old request, so it is skipped.
  always @(posedge clk) begin
    nvmAck <= 1'b0;
    gapQ   <= nvmAck;
    if (nvmReq.req && !nvmAck && !gapQ) begin
      if (waitQ == lat) begin
        nvmAck <= 1'b1;
        waitQ  <= 4'h0;
        if (nvmReq.wr) mem[nvmReq.addr[4:0]] <= nvmReq.wdata;
      end else begin
        waitQ <= waitQ + 4'h1;
      end
    end
  end

  assign nvmRdata = nvmAck ? mem[nvmReq.addr[4:0]] : ~mem[nvmReq.addr[4:0]];
endmodule : nvm_model

// ---- tb.sv ----
`timescale 1ns/1ns
module tb
  import usage_log_pkg::*;
  ;
  // Configuration and instrument state
  logic        clk;
  logic        rst;
  logic        logEnable;
  logic        powerUp;
  logic [21:0] periodMs;
  logic        levelTrigEn;
  logic [7:0]  levelThreshold;
  sample_s     sIn;
  // Store side and status
  nvm_req_s    nvmReq;
  logic        nvmAck;
  logic [31:0] nvmRdata;
  logic [3:0]  lat;
  logic        logging;
  logic [31:0] checksum;
  logic [15:0] writePtr;
  logic        wrapped;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [31:0] expSum = 32'h0000_0000;
  localparam int SLOTS = 4;

  usage_datalogger #(.TICK_CYCLES(1), .ENTRIES(SLOTS)) i_dut (
    .clk(clk), .rst(rst), .logEnable(logEnable), .powerUp(powerUp), .periodMs(periodMs),
    .levelTrigEn(levelTrigEn), .levelThreshold(levelThreshold), .sampleIn(sIn),
    .nvmReq(nvmReq), .nvmAck(nvmAck), .nvmRdata(nvmRdata), .logging(logging),
    .checksum(checksum), .writePtr(writePtr), .wrapped(wrapped)
  );
  nvm_model i_nvm (
    .clk(clk), .nvmReq(nvmReq), .nvmAck(nvmAck), .nvmRdata(nvmRdata), .lat(lat)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // A run of about eight thousand cycles is expected.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for the pointer and an idle store, then checks the new slot and both sums.
  // Each entry adds the zero-extended sample, and a periodic one its counter step.
  task automatic settle(input logic [15:0] exp, input logic [31:0] inc);
    int n;
    n = 0;
    expSum = expSum + 32'(sIn) + inc;
    while (!(writePtr === exp && nvmReq.req === 1'b0) && n < 9000) begin
      @(negedge clk);
      n++;
    end
    chk("writePtr", 32'(writePtr), 32'(exp));
    chk("entry", i_nvm.mem[16 + (int'(exp) + SLOTS - 1) % SLOTS], 32'(sIn));
    chk("checksum", checksum, expSum);
    chk("stored sum", i_nvm.mem[8], expSum);
  endtask : settle

  initial begin
    rst = 1'b1;
    logEnable = 1'b0;
    powerUp = 1'b0;
    periodMs = 22'd4000;
    levelTrigEn = 1'b1;
    levelThreshold = 8'h14;
    lat = 4'h0;
    sIn = {8'h80, 8'h10, 2'd0, 3'd1, 8'h32};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("logging", 32'(logging), 0);
    chk("checksum", checksum, 0);
    chk("wrapped", 32'(wrapped), 0);
    logEnable = 1'b1;
    repeat (200) @(negedge clk);
    chk("logging", 32'(logging), 0);
    powerUp = 1'b1;
    repeat (10) @(negedge clk);
    chk("logging", 32'(logging), 1);
    settle(16'h0001, 32'h0000_0001);
    $display("test start done");
    lat = 4'h3;
    sIn.volume = 8'h11;
    settle(16'h0002, 32'h0000_0000);
    sIn.memory = 2'd1;
    settle(16'h0003, 32'h0000_0000);
    sIn.battery = 8'h70;
    settle(16'h0000, 32'h0000_0000);
    chk("wrapped", 32'(wrapped), 1);
    $display("test change entries done");
    sIn.ambient = 8'h46;
    repeat (100) @(negedge clk);
    chk("writePtr", 32'(writePtr), 0);
    sIn.ambient = 8'h47;
    settle(16'h0001, 32'h0000_0000);
    levelTrigEn = 1'b0;
    sIn.ambient = 8'hC8;
    sIn.environment = 3'd4;
    repeat (100) @(negedge clk);
    chk("writePtr", 32'(writePtr), 1);
    $display("test ambient done");
    settle(16'h0002, 32'h0000_0001);
    chk("counter 0", i_nvm.mem[0], 1);
    chk("counter 1", i_nvm.mem[1], 1);
    chk("on time", i_nvm.mem[0] + i_nvm.mem[1] + i_nvm.mem[2] + i_nvm.mem[3], 2);
    $display("test counters done");
    print_verdict();
  end
endmodule : tb
